//--- sdp_defines.svh
// offsets, field positions, reset values and sizes of the fifo data port
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH
`define SDP_ADDR_W        8
`define SDP_BUS_W         32
`define SDP_DATA_W        16
`define SDP_DATA_MSB      15
`define SDP_DATA_LSB      0
`define SDP_UPPER_MSB     31
`define SDP_UPPER_LSB     16
`define SDP_ALIAS_COUNT   36
`define SDP_ALIAS_BASE    8'h60
`define SDP_ALIAS_LAST    8'hec
`define SDP_ALIAS_23      8'hbc
`define SDP_ALIAS_24      8'hc0
`define SDP_ALIAS_25      8'hc4
`define SDP_ALIAS_26      8'hc8
`define SDP_ALIAS_27      8'hcc
`define SDP_ALIAS_28      8'hd0
`define SDP_ALIAS_29      8'hd4
`define SDP_DATA_RESET    32'h0000_0000
`define SDP_UPPER_ZERO    16'h0000
`define SDP_FIFO_DEPTH    8
`endif

//--- sdp_pkg.sv
// types shared by the fifo data port
package sdp_pkg;
  typedef logic [15:0] sdp_data_t;
  typedef logic [31:0] sdp_word_t;
  // bus phase tracker, gray along idle -> access
  typedef enum logic [1:0] {
    SDP_IDLE   = 2'b00,
    SDP_ACCESS = 2'b01
  } sdp_phase_e;
endpackage

//--- sdp_fifo_if.sv
// signals between the port logic and one fifo
`timescale 1ns/10ps
interface sdp_fifo_if #(
  parameter int W  = 16,
  parameter int LW = 4
);
  logic          push;
  logic [W-1:0]  wdata;
  logic          pop;
  logic          flush;
  logic [W-1:0]  head;
  logic          nonempty;
  logic          room;
  logic [LW-1:0] level;
  modport mem  (input push, wdata, pop, flush, output head, nonempty, room, level);
  modport user (output push, wdata, pop, flush, input head, nonempty, room, level);
endinterface

//--- sdp_fifo.sv
// small first-in first-out store with a registered head word
`timescale 1ns/10ps
module sdp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // port side
  sdp_fifo_if.mem   f
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;
  logic [W-1:0]  head_reg;
  logic          nonempty_reg;
  logic          room_reg;
  logic          do_push;
  logic          do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign do_push     = f.push & room_reg;
  assign do_pop      = f.pop & nonempty_reg;
  assign rd_ptr_next = do_pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
  assign level_next  = level_reg + LW'(do_push) - LW'(do_pop);

  // storage has no reset: entries are only visible through the head
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= f.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (f.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_reg    <= '0;
      nonempty_reg <= 1'b0;
      room_reg     <= 1'b1;
    end else if (f.flush) begin
      level_reg    <= '0;
      nonempty_reg <= 1'b0;
      room_reg     <= 1'b1;
    end else begin
      level_reg    <= level_next;
      nonempty_reg <= (level_next != '0);
      room_reg     <= (level_next != LW'(DEPTH));
    end
  end

  // head always shows the oldest entry; bypass when it is written this cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= '0;
    end else if (f.flush) begin
      head_reg <= '0;
    end else if (do_push && (wr_ptr_reg == rd_ptr_next)) begin
      head_reg <= f.wdata;
    end else begin
      head_reg <= mem_reg[rd_ptr_next];
    end
  end

  assign f.head     = head_reg;
  assign f.nonempty = nonempty_reg;
  assign f.room     = room_reg;
  assign f.level    = level_reg;
endmodule

//--- sdp_port.sv
// fifo data port: peripheral bus slave onto the transmit and receive fifos
`timescale 1ns/10ps
`include "sdp_defines.svh"
module sdp_port #(
  parameter int DEPTH = `SDP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // peripheral bus
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SDP_ADDR_W-1:0] paddr,
  input  wire logic [`SDP_BUS_W-1:0]  pwdata,
  output logic      [`SDP_BUS_W-1:0]  prdata,
  output logic                        pready,
  output logic                        pslverr,
  // controller enable
  input  wire logic                   controller_enable_bit,
  // shifting engine, transmit side
  input  wire logic                   tx_pop,
  output logic      [`SDP_DATA_W-1:0] tx_data,
  output logic                        tx_valid,
  // shifting engine, receive side
  input  wire logic                   rx_push,
  input  wire logic [`SDP_DATA_W-1:0] rx_wdata,
  output logic                        rx_ready
);
  localparam int LW = $clog2(DEPTH + 1);

  sdp_fifo_if #(.W(`SDP_DATA_W), .LW(LW)) tx_f ();
  sdp_fifo_if #(.W(`SDP_DATA_W), .LW(LW)) rx_f ();

  sdp_pkg::sdp_phase_e phase_reg;
  sdp_pkg::sdp_phase_e phase_next;
  sdp_pkg::sdp_word_t  prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;
  logic                setup;
  logic                hit;
  logic                rd_req;
  logic                wr_req;
  logic                tx_push;
  logic                rx_pop;

  // address decode: every aligned word from base to last is the same field
  assign setup = psel & ~penable;
  assign hit   = (paddr >= `SDP_ALIAS_BASE) && (paddr <= `SDP_ALIAS_LAST)
                 && (paddr[1:0] == 2'b00);
  assign rd_req = setup & ~pwrite & hit;
  assign wr_req = setup & pwrite & hit;

  // a write while disabled is dropped silently, no bus error
  assign tx_push = wr_req & controller_enable_bit;
  // popping happens in the setup phase so data is ready for the access phase
  assign rx_pop  = rd_req & rx_f.nonempty;

  // transmit fifo: bus pushes, engine pops
  assign tx_f.push  = tx_push;
  assign tx_f.wdata = pwdata[`SDP_DATA_MSB:`SDP_DATA_LSB];
  assign tx_f.pop   = tx_pop;
  assign tx_f.flush = ~controller_enable_bit;

  // receive fifo: engine pushes, bus pops
  assign rx_f.push  = rx_push;
  assign rx_f.wdata = rx_wdata;
  assign rx_f.pop   = rx_pop;
  assign rx_f.flush = ~controller_enable_bit;

  sdp_fifo #(.W(`SDP_DATA_W), .DEPTH(DEPTH), .LW(LW)) u_tx_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .f       (tx_f.mem)
  );

  sdp_fifo #(.W(`SDP_DATA_W), .DEPTH(DEPTH), .LW(LW)) u_rx_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .f       (rx_f.mem)
  );

  // bus phase tracking
  always_comb begin
    phase_next = sdp_pkg::SDP_IDLE;
    unique case (phase_reg)
      sdp_pkg::SDP_IDLE: begin
        if (setup) begin
          phase_next = sdp_pkg::SDP_ACCESS;
        end
      end
      sdp_pkg::SDP_ACCESS: begin
        if (setup) begin
          phase_next = sdp_pkg::SDP_ACCESS;
        end
      end
      default: begin
        phase_next = sdp_pkg::SDP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= sdp_pkg::SDP_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ready is a flop so the access phase always completes with no wait state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= (phase_next == sdp_pkg::SDP_ACCESS);
    end
  end

  // unmapped addresses answer with an error; nothing moves in either fifo
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup & ~hit;
    end
  end

  // read data: oldest receive word right-justified, upper half zero;
  // an empty receive fifo reads as zero because every setup phase without a pop clears the read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= `SDP_DATA_RESET;
    end else if (rx_pop) begin
      prdata_reg <= {`SDP_UPPER_ZERO, rx_f.head};
    end else if (setup) begin
      prdata_reg <= `SDP_DATA_RESET;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign tx_data  = tx_f.head;
  assign tx_valid = tx_f.nonempty;
  assign rx_ready = rx_f.room;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_setup;
    setup && !pwrite && hit && rx_f.nonempty;
  endsequence

  sequence s_read_access;
    pready && !pslverr;
  endsequence

  property p_read_pops;
    logic [`SDP_DATA_W-1:0] d;
    (s_read_setup, d = rx_f.head) ##1 s_read_access
      |-> (prdata[`SDP_DATA_MSB:`SDP_DATA_LSB] == d);
  endproperty
  a_read_pops: assert property (p_read_pops)
    else $error("read did not return the oldest receive entry");

  property p_read_removes;
    s_read_setup and (!rx_push && controller_enable_bit)
      |=> (rx_f.level == $past(rx_f.level) - LW'(1));
  endproperty
  a_read_removes: assert property (p_read_removes)
    else $error("read did not remove a receive entry");

  property p_write_pushes;
    wr_req && controller_enable_bit && tx_f.room && !(tx_pop && tx_f.nonempty)
      |=> (tx_f.level == $past(tx_f.level) + LW'(1));
  endproperty
  a_write_pushes: assert property (p_write_pushes)
    else $error("write did not add a transmit entry");

  property p_write_to_head;
    logic [`SDP_DATA_W-1:0] d;
    (wr_req && controller_enable_bit && !tx_f.nonempty,
      d = pwdata[`SDP_DATA_MSB:`SDP_DATA_LSB])
      |=> (tx_data == d) && tx_valid;
  endproperty
  a_write_to_head: assert property (p_write_to_head)
    else $error("written word did not reach the empty transmit head");

  property p_no_push_disabled;
    !controller_enable_bit |-> !tx_push;
  endproperty
  a_no_push_disabled: assert property (p_no_push_disabled)
    else $error("transmit push while controller disabled");

  property p_flush;
    !controller_enable_bit |=> (tx_f.level == '0) && (rx_f.level == '0) && !tx_valid;
  endproperty
  a_flush: assert property (p_flush)
    else $error("fifos not emptied while controller disabled");

  property p_last_alias;
    setup && pwrite && controller_enable_bit && (paddr == `SDP_ALIAS_LAST)
      |-> tx_push ##1 (pready && !pslverr);
  endproperty
  a_last_alias: assert property (p_last_alias)
    else $error("last alias did not act as the data field");

  property p_base_alias_read;
    setup && !pwrite && (paddr == `SDP_ALIAS_BASE) && rx_f.nonempty
      |-> rx_pop ##1 (pready && !pslverr);
  endproperty
  a_base_alias_read: assert property (p_base_alias_read)
    else $error("base alias read did not pop");

  property p_unmapped;
    setup && !hit |-> !tx_push && !rx_pop ##1 (pready && pslverr && prdata == '0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access touched a fifo or missed its error");

  property p_empty_reads_zero;
    setup && !pwrite && hit && !rx_f.nonempty |=> pready && (prdata == '0);
  endproperty
  a_empty_reads_zero: assert property (p_empty_reads_zero)
    else $error("empty receive fifo did not read as zero");

  property p_upper_zero;
    pready |-> (prdata[`SDP_UPPER_MSB:`SDP_UPPER_LSB] == `SDP_UPPER_ZERO);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper half of read data not zero");

  property p_upper_ignored;
    logic [`SDP_DATA_W-1:0] d;
    (wr_req && controller_enable_bit && !tx_f.nonempty
      && (pwdata[`SDP_UPPER_MSB:`SDP_UPPER_LSB] != `SDP_UPPER_ZERO),
      d = pwdata[`SDP_DATA_MSB:`SDP_DATA_LSB])
      |=> (tx_data == d);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("upper write bits reached the transmit fifo");

  // zero wait states keep bursts at full rate
  property p_access_ready;
    setup |=> pready;
  endproperty
  a_access_ready: assert property (p_access_ready)
    else $error("setup phase not answered in the next cycle");

  property p_idle_quiet;
    !setup |=> !pready && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("ready or error raised without a setup phase");

  property p_hit_no_error;
    setup && hit |=> !pslverr;
  endproperty
  a_hit_no_error: assert property (p_hit_no_error)
    else $error("alias access answered with an error");

  // a disabled write is dropped quietly, software sees no fault
  property p_disabled_write;
    wr_req && !controller_enable_bit |=> !pslverr && (tx_f.level == '0);
  endproperty
  a_disabled_write: assert property (p_disabled_write)
    else $error("write while disabled reached the transmit fifo");

  property p_write_keeps_rx;
    wr_req && controller_enable_bit && !rx_push
      |=> (rx_f.level == $past(rx_f.level));
  endproperty
  a_write_keeps_rx: assert property (p_write_keeps_rx)
    else $error("write changed the receive fifo");

  property p_read_keeps_tx;
    rd_req && controller_enable_bit && !tx_pop
      |=> (tx_f.level == $past(tx_f.level));
  endproperty
  a_read_keeps_tx: assert property (p_read_keeps_tx)
    else $error("read changed the transmit fifo");

  // a full fifo drops the word; the older entries must survive
  property p_full_drops;
    wr_req && controller_enable_bit && !tx_f.room && !tx_pop
      |=> (tx_f.level == LW'(DEPTH));
  endproperty
  a_full_drops: assert property (p_full_drops)
    else $error("write to a full transmit fifo changed its level");

  property p_empty_no_pop;
    rd_req && !rx_f.nonempty && !rx_push |=> (rx_f.level == '0);
  endproperty
  a_empty_no_pop: assert property (p_empty_no_pop)
    else $error("read of an empty receive fifo moved its level");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("ready stood longer than one access cycle");

  // read data only moves on a setup phase, so a slow master sees it stand
  property p_rdata_holds;
    !setup |=> $stable(prdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed outside a setup phase");
endmodule

//--- sdp_host_model.sv
// bus master model standing in for the processor that owns the data port
`timescale 1ns/10ps
module sdp_host_model (
  // clock
  input  wire logic        clk_sys,
  // peripheral bus
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // a missing ready is counted; the bench turns the count into a mismatch
  int stalls;
  initial begin
    stalls = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer, held until pready is seen high at a rising edge or 8 rising edges have passed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(negedge clk_sys);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk_sys);
    penable = 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) stalls++;
    rd = prdata;
    err = pslverr;
    @(negedge clk_sys);
    psel = 1'b0;
    penable = 1'b0;
    // released lines show inverted values so stale data never looks live
    paddr = ~a;
    pwdata = ~d;
  endtask
  // frame right-justified, upper half free to carry junk
  task automatic put(input logic [7:0] a, input logic [15:0] frame, input logic [15:0] junk);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, {junk, frame}, rd, err);
  endtask
endmodule

//--- test_spi_fifo_data_port.sv
// self-checking bench for the fifo data port
`timescale 1ns/10ps
`include "sdp_defines.svh"
module test_spi_fifo_data_port;
  localparam int DEPTH = 4;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        controller_enable_bit, tx_pop, tx_valid, rx_push, rx_ready, err;
  logic [15:0] tx_data, rx_wdata;
  int          failures, comparisons;
  sdp_port #(.DEPTH(DEPTH)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .controller_enable_bit(controller_enable_bit),
    .tx_pop(tx_pop), .tx_data(tx_data), .tx_valid(tx_valid), .rx_push(rx_push),
    .rx_wdata(rx_wdata), .rx_ready(rx_ready));
  sdp_host_model i_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("counts: failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] alias_addr(input int i);
    return `SDP_ALIAS_BASE + 8'(4 * i);
  endfunction
  // engine side: take the head word and check it
  task automatic pop_chk(input logic [15:0] exp);
    @(negedge clk_sys);
    chk({31'h0, tx_valid}, 32'h1);
    chk({16'h0, tx_data}, {16'h0, exp});
    tx_pop = 1'b1;
    @(negedge clk_sys);
    tx_pop = 1'b0;
  endtask
  task automatic push_rx(input logic [15:0] d);
    @(negedge clk_sys);
    rx_push = 1'b1;
    rx_wdata = d;
    @(negedge clk_sys);
    rx_push = 1'b0;
    rx_wdata = ~d;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask
  task automatic t_reset();
    chk({tx_valid, rx_ready, pready, pslverr}, {28'h0, 4'b0100});
    chk(prdata, `SDP_DATA_RESET);
  endtask
  task automatic t_alias_write();
    controller_enable_bit = 1'b1;
    for (int i = 0; i < `SDP_ALIAS_COUNT; i++) begin
      i_host.put(alias_addr(i), 16'h1000 + 16'(i), 16'hffff);
      pop_chk(16'h1000 + 16'(i));
    end
  endtask
  task automatic t_alias_read();
    for (int i = 0; i < `SDP_ALIAS_COUNT; i++) begin
      push_rx(16'ha500 + 16'(i));
      rd_chk(alias_addr(i), {16'h0, 16'ha500 + 16'(i)});
    end
    rd_chk(`SDP_ALIAS_27, 32'h0000_0000);
  endtask
  // back-to-back fill past capacity in both directions, then drain in order
  task automatic t_order_full();
    for (int i = 0; i <= DEPTH; i++) i_host.put(`SDP_ALIAS_27, 16'h0b00 + 16'(i), 16'h0);
    for (int i = 0; i <= DEPTH; i++) push_rx(16'h0c00 + 16'(i));
    chk({31'h0, rx_ready}, 32'h0);
    for (int i = 0; i < DEPTH; i++) pop_chk(16'h0b00 + 16'(i));
    chk({31'h0, tx_valid}, 32'h0);
    for (int i = 0; i < DEPTH; i++) rd_chk(`SDP_ALIAS_23, {16'h0, 16'h0c00 + 16'(i)});
    chk({31'h0, rx_ready}, 32'h1);
    rd_chk(`SDP_ALIAS_29, 32'h0000_0000);
  endtask
  task automatic t_flush();
    i_host.put(`SDP_ALIAS_24, 16'h5a5a, 16'h0);
    push_rx(16'h3c3c);
    @(negedge clk_sys);
    controller_enable_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({31'h0, tx_valid}, 32'h0);
    i_host.put(`SDP_ALIAS_25, 16'h7777, 16'h0);
    chk({31'h0, tx_valid}, 32'h0);
    @(negedge clk_sys);
    controller_enable_bit = 1'b1;
    rd_chk(`SDP_ALIAS_26, 32'h0000_0000);
  endtask
  // addresses outside the alias span or not word-aligned (such as 8'h62) reach nothing
  task automatic t_unmapped();
    logic [7:0] bad [3];
    bad = '{8'h5c, 8'hf0, 8'h62};
    for (int i = 0; i < 3; i++) begin
      i_host.xfer(1'b1, bad[i], 32'h0000_1234, rd, err);
      chk({31'h0, err}, 32'h1);
      push_rx(16'h4242);
      i_host.xfer(1'b0, bad[i], 32'h0, rd, err);
      chk(rd, 32'h0000_0000);
      chk({31'h0, err}, 32'h1);
      rd_chk(`SDP_ALIAS_28, 32'h0000_4242);
    end
    chk({31'h0, tx_valid}, 32'h0);
  endtask
  initial begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    controller_enable_bit = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_wdata = 16'h0000;
    repeat (12) @(negedge clk_sys);
    t_reset();
    rst_n = 1'b1;
    t_alias_write();
    t_alias_read();
    t_order_full();
    t_flush();
    t_unmapped();
    chk(32'(i_host.stalls), 32'h0);
    end_sim();
  end
  // run needs well under 2000 cycles; this bound only trips on a hang
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule
